// ===== include/sfrp_defs.svh
// Constants for the serial flash read and page program engine.
`ifndef SFRP_DEFS_SVH
`define SFRP_DEFS_SVH

// ==========================================================================
// Opcodes
`define SFRP_OP_READ        8'h03
`define SFRP_OP_FAST        8'h0B
`define SFRP_OP_DOUT        8'h3B
`define SFRP_OP_QOUT        8'h6B
`define SFRP_OP_DIO         8'hBB
`define SFRP_OP_QIO         8'hEB
`define SFRP_OP_WRAP        8'h77
`define SFRP_OP_PROG        8'h02
`define SFRP_OP_WRITE_EN    8'h06

// ==========================================================================
// Frame lengths, field values and sizes
`define SFRP_CMD_BITS       6'h08
`define SFRP_ADDR_BITS      6'h18
`define SFRP_MODE_BITS      6'h08
`define SFRP_DUMMY_CLKS     6'h08
`define SFRP_QIO_DUMMY_CLKS 6'h04
`define SFRP_WRAP_CLKS      6'h20
`define SFRP_CONT_MODE_VAL  2'h2
`define SFRP_WRAP_DEFAULT   3'h4
`define SFRP_WRAP_MIN_BYTES 8'h08
`define SFRP_PAGE_BYTES     256
`define SFRP_BLOCK_COUNT    5'h10
`define SFRP_FIFO_DEPTH     8
`define SFRP_FIFO_WIDTH     32

`endif

// ===== include/sfrp_pkg.sv
// Types shared by the serial flash read and page program engine.
package sfrp_pkg;

	// ======================================================================
	// Frame sequencer states, Gray coded along the usual path
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_CMD    = 4'h1,
		ST_ADDR   = 4'h3,
		ST_MODE   = 4'h2,
		ST_DUMMY  = 4'h6,
		ST_DOUT   = 4'h7,
		ST_PDATA  = 4'h5,
		ST_WRAP   = 4'h4,
		ST_IGNORE = 4'hC
	} sfrp_state_t;

	typedef logic [23:0] sfrp_addr_t;

endpackage

// ===== include/sfrp_strm_if.sv
// Valid and ready stream carrier between the engine and its FIFO.
`timescale 1ns/10ps
`default_nettype none
interface sfrp_strm_if #(
	parameter int WIDTH = 32
) ();
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== verilog/sfrp_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module sfrp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic  clk_i,
	input  wire logic  rst_b_i,
	sfrp_strm_if.sink   wr_if,
	sfrp_strm_if.source rd_if
);
	// ======================================================================
	// Storage and pointers
	// DEPTH must be a power of two; the extra pointer bit tells full from empty.
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0]      wptr;
	logic [AW:0]      rptr;

	wire logic full  = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	wire logic empty = (wptr == rptr);
	wire logic push  = wr_if.valid && !full;
	wire logic pop   = rd_if.valid && rd_if.ready;

	assign wr_if.ready = !full;
	assign rd_if.valid = !empty;
	assign rd_if.data  = mem[rptr[AW-1:0]];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wptr[AW-1:0]] <= wr_if.data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wptr <= '0;
		end else if (push) begin
			wptr <= wptr + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rptr <= '0;
		end else if (pop) begin
			rptr <= rptr + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/sfrp_core.sv
// Serial flash command engine for the read family and page programming.
// ==========================================================================
// Overview of operation
// - Plain read: opcode, 24-bit address, rising-edge sampling.
// - Single-line reads shift data on falling edges.
// - Every read auto-increments address per byte.
// - Plain read ignored while a write cycle runs.
// - Fast read has dummy byte before data.
// - Dual output read returns two bits per clock.
// - Quad output read needs quad enable set.
// - Dual I/O sends address, mode on two lines.
// - Mode bits 10 make next frame opcode-less.
// - Reset frame of ones clears continuous mode.
// - Quad I/O: address, mode, four dummy clocks.
// - Wrap bit4 low enables; bits6:5 pick length.
// - Wrapped quad I/O reads loop within section.
// - Stored wrap setting applies to later reads.
// - Page program needs latch, address, data bytes.
// - Program address wraps inside the page.
// - Only last 256 bytes kept, others untouched.
// - Program discarded unless ended on byte boundary.
// - Chip select rise starts cycle, busy flag high.
// - Write enable latch cleared before cycle ends.
// - Protected pages are never programmed.
// - Write enable opcode sets the latch.
// - Two-line bytes: odd bits one line, even other.
`timescale 1ns/10ps
`default_nettype none
`include "sfrp_defs.svh"
module sfrp_core #(
	parameter int FIFO_DEPTH = `SFRP_FIFO_DEPTH
) (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_B_I,
	input  wire logic        CS_B_I,
	input  wire logic        SCLK_I,
	input  wire logic [3:0]  IO_I,
	output logic      [3:0]  IO_O,
	output logic      [3:0]  IO_OE_O,
	input  wire logic        QUAD_ENABLE_I,
	input  wire logic [4:0]  BLOCK_PROTECT_I,
	input  wire logic        BUSY_OTHER_I,
	output logic             WRITE_IN_PROGRESS_O,
	output logic             WRITE_ENABLE_LATCH_O,
	output logic             CONTINUOUS_MODE_O,
	output logic      [2:0]  WRAP_SETTING_O,
	output logic      [23:0] MEM_RD_ADDR_O,
	input  wire logic [7:0]  MEM_RD_DATA_I,
	output logic      [23:0] MEM_WR_ADDR_O,
	output logic      [7:0]  MEM_WR_DATA_O,
	output logic             MEM_WR_VALID_O,
	input  wire logic        MEM_WR_READY_I
);
	// ======================================================================
	// Pin synchronisers and edge detection
	logic [2:0] cs_q;
	logic [2:0] sclk_q;
	logic [3:0] io_q1;
	logic [3:0] io_q2;

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			cs_q   <= 3'h7;
			sclk_q <= 3'h0;
			io_q1  <= 4'h0;
			io_q2  <= 4'h0;
		end else begin
			cs_q   <= {cs_q[1:0], CS_B_I};
			sclk_q <= {sclk_q[1:0], SCLK_I};
			io_q1  <= IO_I;
			io_q2  <= io_q1;
		end
	end

	wire logic cs_low    = ~cs_q[1];
	wire logic cs_fall   = ~cs_q[1] & cs_q[2];
	wire logic cs_rise   = cs_q[1] & ~cs_q[2];
	wire logic sclk_rise = cs_low & sclk_q[1] & ~sclk_q[2];
	wire logic sclk_fall = cs_low & ~sclk_q[1] & sclk_q[2];

	// ======================================================================
	// Frame state
	sfrp_pkg::sfrp_state_t state;
	sfrp_pkg::sfrp_addr_t  addr;
	logic [7:0]  cmd;
	logic [31:0] sh;
	logic [5:0]  clk_cnt;
	logic [5:0]  phase_len;
	logic [2:0]  lanes;
	logic        cont;
	logic        cont_quad;
	logic        ones;
	logic        got_byte;
	logic [2:0]  wrap_set;
	logic        write_in_progress;
	logic        write_enable_latch;
	logic [7:0]  ob;
	logic [3:0]  obits;
	logic [1:0]  fetch_q;

	// Two-line lanes put bits 7,5,3,1 on line 1 and 6,4,2,0 on line 0.
	wire logic [31:0] sh_n = (lanes == 3'h1) ? {sh[30:0], io_q2[0]} :
		(lanes == 3'h2) ? {sh[29:0], io_q2[1:0]} : {sh[27:0], io_q2};
	wire logic [3:0] in_sel = (lanes == 3'h1) ? {3'h0, io_q2[0]} :
		(lanes == 3'h2) ? {2'h0, io_q2[1:0]} : io_q2;
	wire logic [3:0] lane_mask = (lanes == 3'h1) ? 4'h1 : (lanes == 3'h2) ? 4'h3 : 4'hF;
	wire logic       phase_end = (clk_cnt + 6'h01) == phase_len;
	wire logic       busy      = write_in_progress | BUSY_OTHER_I;

	function automatic logic [2:0] out_lanes(input logic [7:0] c);
		case (c)
			`SFRP_OP_DOUT, `SFRP_OP_DIO: out_lanes = 3'h2;
			`SFRP_OP_QOUT, `SFRP_OP_QIO: out_lanes = 3'h4;
			default:                     out_lanes = 3'h1;
		endcase
	endfunction

	// Protected region counts 64 KiB blocks from the top, or from the bottom
	// when bit 3 is set; bit 4 is not used by this decode.
	function automatic logic is_protected(input logic [4:0] bp, input logic [23:0] a);
		logic [4:0] n;
		logic [4:0] blk;
		n   = (bp[2:0] >= 3'h5) ? `SFRP_BLOCK_COUNT : 5'((5'h01 << bp[2:0]) >> 1);
		blk = {1'h0, a[19:16]};
		is_protected = bp[3] ? (blk < n) : ((blk + n) >= `SFRP_BLOCK_COUNT);
	endfunction

	wire logic [2:0] olanes = out_lanes(cmd);

	// Wrap applies to quad I/O reads only, bounded inside the 256-byte page.
	wire logic       wrap_on  = (cmd == `SFRP_OP_QIO) && !wrap_set[0];
	wire logic [7:0] wmask    = 8'((`SFRP_WRAP_MIN_BYTES << wrap_set[2:1]) - 8'h01);
	wire logic [23:0] lin_addr = addr + 24'h000001;
	wire logic [23:0] next_addr = wrap_on ?
		{addr[23:8], (addr[7:0] & ~wmask) | (lin_addr[7:0] & wmask)} : lin_addr;

	wire logic byte_in   = sclk_rise && (state == sfrp_pkg::ST_PDATA) && phase_end;
	wire logic prog_addr = sclk_rise && (state == sfrp_pkg::ST_ADDR) && phase_end &&
		(cmd == `SFRP_OP_PROG);
	wire logic byte_sent = sclk_fall && (state == sfrp_pkg::ST_DOUT) &&
		(obits == {1'h0, olanes});
	wire logic fetch_go  = (sclk_rise && (state == sfrp_pkg::ST_ADDR) && phase_end &&
		(cmd != `SFRP_OP_PROG)) || byte_sent;
	wire logic prog_go   = cs_rise && (state == sfrp_pkg::ST_PDATA) && (clk_cnt == 6'h00) &&
		got_byte && !is_protected(BLOCK_PROTECT_I, addr);
	wire logic latch_set = cs_rise && (state == sfrp_pkg::ST_IGNORE) && !write_in_progress &&
		(cmd == `SFRP_OP_WRITE_EN) && (clk_cnt == 6'h00);

	// ======================================================================
	// Frame sequencer
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			state     <= sfrp_pkg::ST_IDLE;
			addr      <= 24'h000000;
			cmd       <= 8'h00;
			sh        <= 32'h00000000;
			clk_cnt   <= 6'h00;
			phase_len <= `SFRP_CMD_BITS;
			lanes     <= 3'h1;
			cont      <= 1'b0;
			cont_quad <= 1'b0;
			ones      <= 1'b0;
			got_byte  <= 1'b0;
			wrap_set  <= `SFRP_WRAP_DEFAULT;
		end else if (cs_q[1]) begin
			state <= sfrp_pkg::ST_IDLE;
			if (cs_rise && (state == sfrp_pkg::ST_ADDR) && cont && ones) begin
				cont <= 1'b0;
			end
		end else if (cs_fall) begin
			clk_cnt  <= 6'h00;
			ones     <= 1'b1;
			got_byte <= 1'b0;
			if (cont) begin
				state     <= busy ? sfrp_pkg::ST_IGNORE : sfrp_pkg::ST_ADDR;
				cmd       <= cont_quad ? `SFRP_OP_QIO : `SFRP_OP_DIO;
				lanes     <= cont_quad ? 3'h4 : 3'h2;
				phase_len <= cont_quad ? `SFRP_ADDR_BITS / 6'h04 : `SFRP_ADDR_BITS / 6'h02;
			end else begin
				state     <= sfrp_pkg::ST_CMD;
				lanes     <= 3'h1;
				phase_len <= `SFRP_CMD_BITS;
			end
		end else if (sclk_rise) begin
			sh      <= sh_n;
			clk_cnt <= phase_end ? 6'h00 : (clk_cnt == 6'h3F) ? clk_cnt : clk_cnt + 6'h01;
			if (state == sfrp_pkg::ST_ADDR) begin
				ones <= ones & (in_sel == lane_mask);
			end
			if (phase_end) begin
				case (state)
					sfrp_pkg::ST_CMD: begin
						cmd       <= sh_n[7:0];
						phase_len <= `SFRP_ADDR_BITS;
						case (sh_n[7:0])
							`SFRP_OP_READ, `SFRP_OP_FAST, `SFRP_OP_DOUT: begin
								state <= busy ? sfrp_pkg::ST_IGNORE : sfrp_pkg::ST_ADDR;
							end
							`SFRP_OP_QOUT: begin
								state <= (busy || !QUAD_ENABLE_I) ?
									sfrp_pkg::ST_IGNORE : sfrp_pkg::ST_ADDR;
							end
							`SFRP_OP_DIO: begin
								state     <= busy ? sfrp_pkg::ST_IGNORE : sfrp_pkg::ST_ADDR;
								lanes     <= 3'h2;
								phase_len <= `SFRP_ADDR_BITS / 6'h02;
							end
							`SFRP_OP_QIO: begin
								state     <= (busy || !QUAD_ENABLE_I) ?
									sfrp_pkg::ST_IGNORE : sfrp_pkg::ST_ADDR;
								lanes     <= 3'h4;
								phase_len <= `SFRP_ADDR_BITS / 6'h04;
							end
							`SFRP_OP_WRAP: begin
								state     <= sfrp_pkg::ST_WRAP;
								phase_len <= `SFRP_WRAP_CLKS;
							end
							`SFRP_OP_PROG: begin
								state <= (write_enable_latch && !busy) ?
									sfrp_pkg::ST_ADDR : sfrp_pkg::ST_IGNORE;
							end
							default: begin
								state <= sfrp_pkg::ST_IGNORE;
							end
						endcase
					end
					sfrp_pkg::ST_ADDR: begin
						addr <= sh_n[23:0];
						if (cmd == `SFRP_OP_PROG) begin
							state     <= sfrp_pkg::ST_PDATA;
							phase_len <= `SFRP_CMD_BITS;
						end else if ((cmd == `SFRP_OP_DIO) || (cmd == `SFRP_OP_QIO)) begin
							state     <= sfrp_pkg::ST_MODE;
							phase_len <= 6'(`SFRP_MODE_BITS / {3'h0, lanes});
						end else if (cmd == `SFRP_OP_READ) begin
							state <= sfrp_pkg::ST_DOUT;
						end else begin
							state     <= sfrp_pkg::ST_DUMMY;
							phase_len <= `SFRP_DUMMY_CLKS;
						end
					end
					sfrp_pkg::ST_MODE: begin
						cont      <= (sh_n[5:4] == `SFRP_CONT_MODE_VAL);
						cont_quad <= (cmd == `SFRP_OP_QIO);
						if (cmd == `SFRP_OP_QIO) begin
							state     <= sfrp_pkg::ST_DUMMY;
							phase_len <= `SFRP_QIO_DUMMY_CLKS;
						end else begin
							state <= sfrp_pkg::ST_DOUT;
						end
					end
					sfrp_pkg::ST_DUMMY: begin
						state <= sfrp_pkg::ST_DOUT;
					end
					sfrp_pkg::ST_WRAP: begin
						wrap_set <= sh_n[6:4];
						state    <= sfrp_pkg::ST_IGNORE;
					end
					sfrp_pkg::ST_PDATA: begin
						addr[7:0] <= addr[7:0] + 8'h01;
						got_byte  <= 1'b1;
					end
					default: begin
						state <= state;
					end
				endcase
			end
		end else if (byte_sent) begin
			addr <= next_addr;
		end
	end

	// ======================================================================
	// Read data path
	// Memory answers one cycle after the address moves, well inside half a
	// link clock, so a byte is ready before the falling edge that needs it.
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			fetch_q <= 2'h0;
		end else begin
			fetch_q <= {fetch_q[0], fetch_go};
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			ob      <= 8'h00;
			obits   <= 4'h0;
			IO_O    <= 4'h0;
			IO_OE_O <= 4'h0;
		end else if (cs_q[1]) begin
			obits   <= 4'h0;
			IO_OE_O <= 4'h0;
		end else if (fetch_q[1]) begin
			ob    <= MEM_RD_DATA_I;
			obits <= 4'h8;
		end else if (sclk_fall && (state == sfrp_pkg::ST_DOUT)) begin
			case (olanes)
				3'h2: begin
					IO_O    <= {2'h0, ob[7:6]};
					IO_OE_O <= 4'h3;
				end
				3'h4: begin
					IO_O    <= ob[7:4];
					IO_OE_O <= 4'hF;
				end
				default: begin
					IO_O    <= {2'h0, ob[7], 1'h0};
					IO_OE_O <= 4'h2;
				end
			endcase
			ob    <= ob << olanes;
			obits <= obits - {1'h0, olanes};
		end
	end

	// ======================================================================
	// Page buffer and program cycle
	logic [7:0]                  page_mem [0:`SFRP_PAGE_BYTES-1];
	logic [`SFRP_PAGE_BYTES-1:0] page_vld;
	logic [8:0]                  widx;
	logic [15:0]                 pbase;

	// Later bytes overwrite earlier ones at the same offset.
	always_ff @(posedge SYS_CLK_I) begin
		if (byte_in) begin
			page_mem[addr[7:0]] <= sh_n[7:0];
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			page_vld <= '0;
		end else if (prog_addr) begin
			page_vld <= '0;
		end else if (byte_in) begin
			page_vld[addr[7:0]] <= 1'b1;
		end
	end

	sfrp_strm_if #(.WIDTH(`SFRP_FIFO_WIDTH)) push_if ();
	sfrp_strm_if #(.WIDTH(`SFRP_FIFO_WIDTH)) drain_if ();

	// The walk stalls on a written offset while the FIFO is full, so a slow array sets the pace.
	assign push_if.valid  = write_in_progress && !widx[8] && page_vld[widx[7:0]];
	assign push_if.data   = {pbase, widx[7:0], page_mem[widx[7:0]]};
	assign drain_if.ready = MEM_WR_READY_I;

	sfrp_fifo #(
		.WIDTH(`SFRP_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i  (SYS_CLK_I),
		.rst_b_i(RST_B_I),
		.wr_if  (push_if),
		.rd_if  (drain_if)
	);

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_B_I) begin
			write_in_progress  <= 1'b0;
			write_enable_latch <= 1'b0;
			widx               <= 9'h000;
			pbase              <= 16'h0000;
		end else if (prog_go) begin
			write_in_progress  <= 1'b1;
			write_enable_latch <= 1'b0;
			widx               <= 9'h000;
			pbase              <= addr[23:8];
		end else if (latch_set) begin
			write_enable_latch <= 1'b1;
		end else if (write_in_progress && !widx[8] &&
			(!page_vld[widx[7:0]] || push_if.ready)) begin
			widx <= widx + 9'h001;
		end else if (write_in_progress && widx[8] && !drain_if.valid) begin
			write_in_progress <= 1'b0;
		end
	end

	assign WRITE_IN_PROGRESS_O  = write_in_progress;
	assign WRITE_ENABLE_LATCH_O = write_enable_latch;
	assign CONTINUOUS_MODE_O    = cont;
	assign WRAP_SETTING_O       = wrap_set;
	assign MEM_RD_ADDR_O        = addr;
	assign MEM_WR_VALID_O       = drain_if.valid;
	assign MEM_WR_ADDR_O        = drain_if.data[31:8];
	assign MEM_WR_DATA_O        = drain_if.data[7:0];

	// ======================================================================
	// Checks
	a_line_release: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_B_I) cs_rise |=> (IO_OE_O == 4'h0)
	) else $error("output lines still driven after chip select rose");

	a_prog_start: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		prog_go |=> write_in_progress && (widx == 9'h000)
	) else $error("program cycle did not start on chip select rise");

	a_latch_clear: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_B_I) $rose(write_in_progress) |-> !write_enable_latch
	) else $error("write enable latch still set in program cycle");

	a_read_reject: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		sclk_rise && (state == sfrp_pkg::ST_CMD) && phase_end &&
		(sh_n[7:0] == `SFRP_OP_READ) && busy |=> (state == sfrp_pkg::ST_IGNORE)
	) else $error("read accepted while busy");

	a_quad_gate: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		sclk_rise && (state == sfrp_pkg::ST_CMD) && phase_end &&
		(sh_n[7:0] == `SFRP_OP_QOUT) && !QUAD_ENABLE_I |=> (state == sfrp_pkg::ST_IGNORE)
	) else $error("quad read accepted without quad enable");

	a_page_wrap: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		byte_in && (addr[7:0] == 8'hFF) |=> (addr[7:0] == 8'h00) && $stable(addr[23:8])
	) else $error("program address left its page");

	a_write_enable_cmd_set: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_B_I) latch_set |=> write_enable_latch
	) else $error("write enable opcode did not set the latch");

	a_cont_entry: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		cs_fall && cont && !busy |=> (state == sfrp_pkg::ST_ADDR) ##1 cs_low[*2]
	) else $error("continuous mode frame did not start at address");

	a_single_line: assert property (
		@(posedge SYS_CLK_I) disable iff (!RST_B_I)
		sclk_fall && (state == sfrp_pkg::ST_DOUT) && (olanes == 3'h1) |=> (IO_OE_O == 4'h2)
	) else $error("single-line read drove the wrong line");
endmodule
`default_nettype wire

// ===== tb/sfrp_host_model.sv
// Host controller model that frames commands on the serial link.
`timescale 1ns/10ps
`default_nettype none
module sfrp_host_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] dut_io_i,
	input  wire logic [3:0] dut_oe_i,
	output logic            cs_b_o,
	output logic            sclk_o,
	output logic      [3:0] io_o
);
	logic [3:0] drv;
	logic [3:0] val;
	logic [3:0] last;
	logic [3:0] oe_seen;

	// Released lines toggle every cycle so stale data never reads as valid.
	always_comb begin
		for (int k = 0; k < 4; k++)
			io_o[k] = dut_oe_i[k] ? dut_io_i[k] : (drv[k] ? val[k] : ~last[k]);
	end

	always @(posedge clk_i) begin
		last <= io_o;
		if (!cs_b_o)
			oe_seen <= oe_seen | dut_oe_i;
	end

	initial begin
		cs_b_o = 1'b1;
		sclk_o = 1'b0;
		drv = 4'h0;
		val = 4'h0;
		last = 4'h0;
		oe_seen = 4'h0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic open_frame();
		oe_seen = 4'h0;
		cs_b_o = 1'b0;
		wt(4);
	endtask

	task automatic close_frame();
		wt(4);
		drv = 4'h0;
		cs_b_o = 1'b1;
		wt(8);
	endtask

	// Clock stays low outside frames; each group goes out before the rise.
	task automatic shift(input int l, input int n, input bit send,
		input logic [63:0] dout, output logic [63:0] din);
		din = 64'h0;
		for (int c = n - 1; c >= 0; c--) begin
			drv = send ? (4'hF >> (4 - l)) : 4'h0;
			val = 4'(dout >> (c * l));
			wt(4);
			sclk_o = 1'b1;
			wt(4);
			din = (din << l) | 64'((l == 1 ? io_o >> 1 : io_o) & (4'hF >> (4 - l)));
			sclk_o = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the serial flash read and page program engine.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        quad_enable = 1'b0;
	logic [4:0]  bp = 5'h00;
	logic        busy = 1'b0;
	logic        wr_rdy = 1'b0;
	logic [7:0]  rd_data = 8'h00;
	wire         cs_b;
	wire         sclk;
	wire  [3:0]  io_w;
	wire  [3:0]  dut_io;
	wire  [3:0]  dut_oe;
	wire         write_in_progress;
	wire         write_enable_latch;
	wire         cont;
	wire  [2:0]  wrap;
	wire  [23:0] rd_addr;
	wire  [23:0] wr_addr;
	wire  [7:0]  wr_data;
	wire         wr_valid;
	logic [31:0] wq[$];
	int          error_cnt = 0;
	int          compares = 0;
	int          n;

	always #20 sys_clk = ~sys_clk;

	sfrp_core dut (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .CS_B_I(cs_b), .SCLK_I(sclk),
		.IO_I(io_w), .IO_O(dut_io), .IO_OE_O(dut_oe), .QUAD_ENABLE_I(quad_enable),
		.BLOCK_PROTECT_I(bp), .BUSY_OTHER_I(busy), .WRITE_IN_PROGRESS_O(write_in_progress),
		.WRITE_ENABLE_LATCH_O(write_enable_latch), .CONTINUOUS_MODE_O(cont),
		.WRAP_SETTING_O(wrap),
		.MEM_RD_ADDR_O(rd_addr), .MEM_RD_DATA_I(rd_data), .MEM_WR_ADDR_O(wr_addr),
		.MEM_WR_DATA_O(wr_data), .MEM_WR_VALID_O(wr_valid), .MEM_WR_READY_I(wr_rdy));

	sfrp_host_model host (.clk_i(sys_clk), .dut_io_i(dut_io), .dut_oe_i(dut_oe),
		.cs_b_o(cs_b), .sclk_o(sclk), .io_o(io_w));

	// ======================================================================
	// Array model; the write port stalls every other cycle.
	function automatic logic [7:0] mem(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
	endfunction

	always @(posedge sys_clk) begin
		rd_data <= mem(rd_addr);
		if (wr_valid && wr_rdy)
			wq.push_back({wr_addr, wr_data});
		#1 wr_rdy <= ~wr_rdy;
	end

	// ======================================================================
	// Access tasks
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	task automatic frame(input int l, input int c, input logic [63:0] v);
		logic [63:0] d;
		host.open_frame();
		host.shift(l, c, 1'b1, v, d);
		host.close_frame();
	endtask

	// Reads three bytes; op 0 omits the opcode, w is the wrap section or 0.
	task automatic rd(input logic [7:0] op, input int al, input int ml, input logic [7:0] md,
		input int dl, input int dc, input logic [23:0] a, input int w, input logic [3:0] oe);
		logic [63:0] d;
		logic [23:0] e;
		host.open_frame();
		if (op != 8'h00)
			host.shift(1, 8, 1'b1, 64'(op), d);
		host.shift(al, (24 + ml) / al, 1'b1, ml != 0 ? 64'({a, md}) : 64'(a), d);
		if (dc > 0)
			host.shift(al, dc, al == 1, 64'h0, d);
		host.shift(dl, 24 / dl, 1'b0, 64'h0, d);
		for (int i = 0; i < 3 && oe != 4'h0; i++) begin
			e = w != 0 ? (a & ~24'(w - 1)) | ((a + 24'(i)) & 24'(w - 1)) : a + 24'(i);
			chk("read byte", d[23 - 8 * i -: 8], mem(e));
		end
		chk("line enables", host.oe_seen, oe);
		host.close_frame();
		chk("lines released", dut_oe, 4'h0);
	endtask

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		host.wt(90000);
		error_cnt++;
		close_out();
	end

	initial begin
		host.wt(8);
		rst_b = 1'b1;
		host.wt(4);
		chk("wrap setting", wrap, 3'h4);
		chk("status", {write_in_progress, write_enable_latch, cont, dut_oe}, 7'h00);
		rd(8'h03, 1, 0, 8'h00, 1, 0, 24'h12FFFE, 0, 4'h2);
		rd(8'h0B, 1, 0, 8'h00, 1, 8, 24'h0000FF, 0, 4'h2);
		rd(8'h3B, 1, 0, 8'h00, 2, 8, 24'h345678, 0, 4'h3);
		rd(8'h6B, 1, 0, 8'h00, 4, 8, 24'h0ABCDE, 0, 4'h0);
		quad_enable = 1'b1;
		rd(8'h6B, 1, 0, 8'h00, 4, 8, 24'h0ABCDE, 0, 4'hF);
		$display("test single and output reads finished");
		rd(8'hBB, 2, 8, 8'h20, 2, 0, 24'h001230, 0, 4'h3);
		chk("continuous mode", cont, 1'b1);
		rd(8'h00, 2, 8, 8'h20, 2, 0, 24'h00ABC0, 0, 4'h3);
		frame(2, 8, 64'hFFFF);
		chk("continuous mode", cont, 1'b0);
		rd(8'hEB, 4, 8, 8'h20, 4, 4, 24'h0011F0, 0, 4'hF);
		rd(8'h00, 4, 8, 8'h00, 4, 4, 24'h002200, 0, 4'hF);
		chk("continuous mode", cont, 1'b0);
		$display("test io reads finished");
		for (int k = 0; k < 4; k++) begin
			frame(1, 40, 64'({8'h77, 24'h000000, 1'b0, 2'(k), 5'h00}));
			chk("wrap setting", wrap, {2'(k), 1'b0});
			rd(8'hEB, 4, 8, 8'h00, 4, 4, 24'h0001FE, 8 << k, 4'hF);
		end
		frame(1, 40, 64'h77_000000_10);
		chk("wrap setting", wrap, 3'h1);
		rd(8'hEB, 4, 8, 8'h00, 4, 4, 24'h0001FE, 0, 4'hF);
		$display("test wrap finished");
		busy = 1'b1;
		rd(8'h03, 1, 0, 8'h00, 1, 0, 24'h000040, 0, 4'h0);
		busy = 1'b0;
		frame(1, 8, 64'h06);
		chk("write enable latch", write_enable_latch, 1'b1);
		wq.delete();
		frame(1, 56, 64'h02_0003FE_A1B2C3);
		chk("write in progress", write_in_progress, 1'b1);
		chk("write enable latch", write_enable_latch, 1'b0);
		rd(8'h03, 1, 0, 8'h00, 1, 0, 24'h000300, 0, 4'h0);
		n = 0;
		while (write_in_progress === 1'b1 && n < 5000) begin
			host.wt(1);
			n++;
		end
		chk("write in progress", write_in_progress, 1'b0);
		chk("write count", wq.size(), 3);
		chk("page write 0", wq[0], 32'h000300C3);
		chk("page write 1", wq[1], 32'h0003FEA1);
		chk("page write 2", wq[2], 32'h0003FFB2);
		bp = 5'h01;
		frame(1, 8, 64'h06);
		frame(1, 40, 64'h02_0F0000_5A);
		chk("write in progress", write_in_progress, 1'b0);
		bp = 5'h00;
		frame(1, 44, 64'h02_000010_ABC);
		chk("write in progress", write_in_progress, 1'b0);
		host.wt(300);
		chk("write count", wq.size(), 3);
		$display("test page program finished");
		close_out();
	end
endmodule
`default_nettype wire
